// File: logic/audio_status_coeff_id_regs.sv
// What this block does
// - Bit 0 reports resampler PLL unlock, resets one
// - Bit 1 reports S/PDIF receiver unlock, resets one
// - Bit 10 enables mute on compressed frames
// - Bit 11 enables mute on missing marker
// - Two registers hold coefficient, index, flag
// - Identification registers ignore every write
// - Low byte of second ID is revision
`timescale 1ns/1ps
`default_nettype none

module audio_status_coeff_id_regs #(
    parameter logic [7:0] REVISION = audio_regs_pkg::REVISION_VAL
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Register access port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // Status from the audio path, asynchronous
    input  wire logic        pll_unlock_i,
    input  wire logic        spdif_unlock_i,
    input  wire logic        frame_hdr_i,
    input  wire logic        channel_status_marker_i,
    // Controls to the audio path
    output logic             automute_o,
    output logic             compressed_frame_automute_en_o,
    output logic             chan_status_automute_en_o,
    output logic [19:0]      coefficient_value_o,
    output logic [7:0]       coefficient_index_o,
    output logic             coefficient_rw_o
);

    typedef struct packed {
        logic        frame_amen;
        logic        chan_amen;
        logic [15:0] coef_low;
        logic [7:0]  coef_idx;
        logic        coef_rw;
        logic [3:0]  coef_hi;
        logic [15:0] rdata;
        logic        rvalid;
        logic        mute;
    } regs_s;

    regs_s st_r;
    regs_s st_nxt;

    lock_sync_if sync_bus ();

    lock_sync u_sync (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .pll_unlock_i   (pll_unlock_i),
        .spdif_unlock_i (spdif_unlock_i),
        .frame_hdr_i    (frame_hdr_i),
        .marker_seen_i  (channel_status_marker_i),
        .sync           (sync_bus.src)
    );

    function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
        hit = (a == off);
    endfunction

    logic [15:0] status_word;
    logic [15:0] read_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[audio_regs_pkg::BIT_PLL_UNLOCK]   = sync_bus.pll_unlock;
        status_word[audio_regs_pkg::BIT_SPDIF_UNLOCK] = sync_bus.spdif_unlock;
        status_word[audio_regs_pkg::BIT_FRAME_AMEN]   = st_r.frame_amen;
        status_word[audio_regs_pkg::BIT_CHAN_AMEN]    = st_r.chan_amen;
    end

    always_comb begin
        read_word = 16'h0000;
        if (hit(reg_addr_i, audio_regs_pkg::OFF_STATUS)) begin
            read_word = status_word;
        end else if (hit(reg_addr_i, audio_regs_pkg::OFF_COEF_LOW)) begin
            read_word = st_r.coef_low;
        end else if (hit(reg_addr_i, audio_regs_pkg::OFF_COEF_HIGH)) begin
            read_word = {st_r.coef_idx, st_r.coef_rw, 3'h0, st_r.coef_hi};
        end else if (hit(reg_addr_i, audio_regs_pkg::OFF_ID_FIRST)) begin
            read_word = audio_regs_pkg::ID_FIRST_VAL;
        end else if (hit(reg_addr_i, audio_regs_pkg::OFF_ID_SECOND)) begin
            read_word = {audio_regs_pkg::ID_SECOND_HI, REVISION};
        end
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            st_nxt.rdata = read_word;
        end
        // Writes to reserved status bits and ID registers fall through unused
        if (reg_wr_i) begin
            if (hit(reg_addr_i, audio_regs_pkg::OFF_STATUS)) begin
                st_nxt.frame_amen = reg_wdata_i[audio_regs_pkg::BIT_FRAME_AMEN];
                st_nxt.chan_amen  = reg_wdata_i[audio_regs_pkg::BIT_CHAN_AMEN];
            end else if (hit(reg_addr_i, audio_regs_pkg::OFF_COEF_LOW)) begin
                st_nxt.coef_low = reg_wdata_i;
            end else if (hit(reg_addr_i, audio_regs_pkg::OFF_COEF_HIGH)) begin
                st_nxt.coef_idx = reg_wdata_i[audio_regs_pkg::COEF_IDX_LSB +: 8];
                st_nxt.coef_rw  = reg_wdata_i[audio_regs_pkg::COEF_RW_BIT];
                st_nxt.coef_hi  = reg_wdata_i[3:0];
            end
        end
        // Mute follows the synchronised detectors; three cycles later than the raw inputs
        st_nxt.mute = (st_r.frame_amen & sync_bus.frame_hdr)
                    | (st_r.chan_amen & ~sync_bus.marker_seen);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '{frame_amen: audio_regs_pkg::RST_FRAME_AMEN,
                      chan_amen:  audio_regs_pkg::RST_CHAN_AMEN,
                      default:    '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o                    = st_r.rdata;
    assign reg_rvalid_o                   = st_r.rvalid;
    assign automute_o                     = st_r.mute;
    assign compressed_frame_automute_en_o = st_r.frame_amen;
    assign chan_status_automute_en_o      = st_r.chan_amen;
    assign coefficient_value_o            = {st_r.coef_hi, st_r.coef_low};
    assign coefficient_index_o            = st_r.coef_idx;
    assign coefficient_rw_o               = st_r.coef_rw;

endmodule

`default_nettype wire

// File: include/audio_regs_pkg.sv
`default_nettype none

package audio_regs_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [6:0] OFF_STATUS    = 7'h76;
    localparam logic [6:0] OFF_COEF_LOW  = 7'h78;
    localparam logic [6:0] OFF_COEF_HIGH = 7'h7A;
    localparam logic [6:0] OFF_ID_FIRST  = 7'h7C;
    localparam logic [6:0] OFF_ID_SECOND = 7'h7E;

    // Status register field positions
    localparam int BIT_PLL_UNLOCK   = 0;
    localparam int BIT_SPDIF_UNLOCK = 1;
    localparam int BIT_FRAME_AMEN   = 10;
    localparam int BIT_CHAN_AMEN    = 11;

    // Status register reset values
    localparam logic RST_PLL_UNLOCK   = 1'b1;
    localparam logic RST_SPDIF_UNLOCK = 1'b1;
    localparam logic RST_FRAME_AMEN   = 1'b1;
    localparam logic RST_CHAN_AMEN    = 1'b0;

    // Coefficient address/high register layout
    localparam int COEF_W        = 20;
    localparam int COEF_IDX_W    = 8;
    localparam int COEF_IDX_LSB  = 8;
    localparam int COEF_RW_BIT   = 7;
    localparam int COEF_HI_W     = 4;
    localparam int COEF_LOW_W    = 16;

    // Identification: arbitrary neutral values
    localparam logic [15:0] ID_FIRST_VAL  = 16'h1234;
    localparam logic [7:0]  ID_SECOND_HI  = 8'h56;
    localparam logic [7:0]  REVISION_VAL  = 8'h01;

endpackage

`default_nettype wire

// File: include/lock_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface lock_sync_if;
    logic pll_unlock;
    logic spdif_unlock;
    logic frame_hdr;
    logic marker_seen;
    modport src (output pll_unlock, output spdif_unlock, output frame_hdr, output marker_seen);
    modport dst (input pll_unlock, input spdif_unlock, input frame_hdr, input marker_seen);
endinterface

`default_nettype wire

// File: logic/lock_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for the asynchronous status levels
module lock_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Raw levels
    input  wire logic pll_unlock_i,
    input  wire logic spdif_unlock_i,
    input  wire logic frame_hdr_i,
    input  wire logic marker_seen_i,
    // Synchronised levels
    lock_sync_if.src  sync
);

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] stable;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta   = {marker_seen_i, frame_hdr_i, spdif_unlock_i, pll_unlock_i};
        st_nxt.stable = st_r.meta;
    end

    // Unlock flags start high so nothing reports lock before a real sample
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '{meta: 4'h3, stable: 4'h3};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync.pll_unlock   = st_r.stable[0];
    assign sync.spdif_unlock = st_r.stable[1];
    assign sync.frame_hdr    = st_r.stable[2];
    assign sync.marker_seen  = st_r.stable[3];

endmodule

`default_nettype wire

// File: verif/audio_path_model.sv
`timescale 1ns/1ps
`default_nettype none
module audio_path_model (
    // Clock and wanted levels: pll, spdif, header, marker
    input  wire logic       clk_i,
    input  wire logic [3:0] want_i,
    // Levels toward the block
    output var  logic [3:0] lvl_o = 4'hD
);
    // Moves on the falling edge, well clear of the sampling edge
    always @(negedge clk_i) begin
        lvl_o <= want_i;
    end
endmodule
`default_nettype wire

// File: verif/audio_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module audio_regs_monitor #(parameter logic [7:0] REVISION = audio_regs_pkg::REVISION_VAL) (
    // Watched ports
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [6:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        pll_unlock_i,
    input wire logic        spdif_unlock_i,
    input wire logic        compressed_frame_automute_en_o,
    input wire logic        chan_status_automute_en_o,
    input wire logic [19:0] coefficient_value_o,
    input wire logic [7:0]  coefficient_index_o,
    input wire logic        coefficient_rw_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Unlock bits of both sync stages reset to one, so reads right after reset are skipped
    lock_flags_a: assert property (reg_rd_i && reg_addr_i == 7'h76 && !$past(srst_i)
        && !$past(srst_i, 2) |=> reg_rdata_o[1:0] == $past({spdif_unlock_i, pll_unlock_i}, 3))
        else $error("Lock flags wrong");
    frame_en_a: assert property (reg_wr_i && reg_addr_i == 7'h76 |=>
        compressed_frame_automute_en_o == $past(reg_wdata_i[10])) else $error("Frame enable");
    chan_en_a: assert property (reg_wr_i && reg_addr_i == 7'h76 |=>
        chan_status_automute_en_o == $past(reg_wdata_i[11])) else $error("Marker enable");
    coef_low_a: assert property (reg_wr_i && reg_addr_i == 7'h78 |=>
        coefficient_value_o[15:0] == $past(reg_wdata_i)) else $error("Coefficient low");
    coef_high_a: assert property (reg_wr_i && reg_addr_i == 7'h7A |=> {coefficient_index_o,
        coefficient_rw_o, coefficient_value_o[19:16]} == $past({reg_wdata_i[15:7],
        reg_wdata_i[3:0]})) else $error("Coefficient high");
    id_first_a: assert property (reg_rd_i && reg_addr_i == 7'h7C |=> reg_rvalid_o &&
        reg_rdata_o == audio_regs_pkg::ID_FIRST_VAL) else $error("First identity");
    rev_field_a: assert property (reg_rd_i && reg_addr_i == 7'h7E |=> reg_rvalid_o &&
        reg_rdata_o == {audio_regs_pkg::ID_SECOND_HI, REVISION}) else $error("Second identity");
    rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == 7'h76 |=> reg_rvalid_o &&
        reg_rdata_o[15:2] == {4'h0, $past({chan_status_automute_en_o,
        compressed_frame_automute_en_o}), 8'h00}) else $error("Status upper bits");
    cover property (reg_wr_i && reg_addr_i == 7'h7C);
    cover property (reg_rd_i && reg_addr_i == 7'h7A);
    cover property (reg_wr_i && reg_addr_i == 7'h76 && !reg_wdata_i[10]);
endmodule
bind audio_status_coeff_id_regs audio_regs_monitor #(.REVISION(REVISION)) mon (.*);
`default_nettype wire

// File: verif/test_audio_status_coeff_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module test_audio_status_coeff_id_regs;
    logic clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    logic [3:0] want = 4'hD, lvl;
    logic reg_rvalid_o, automute_o, compressed_frame_automute_en_o, chan_status_automute_en_o;
    logic coefficient_rw_o;
    logic [19:0] coefficient_value_o;
    logic [7:0] coefficient_index_o;
    int failures = 0, n_compared = 0;
    audio_path_model path (.clk_i, .want_i(want), .lvl_o(lvl));
    audio_status_coeff_id_regs dut (.clk_i, .srst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .pll_unlock_i(lvl[3]),
        .spdif_unlock_i(lvl[2]), .frame_hdr_i(lvl[1]), .channel_status_marker_i(lvl[0]),
        .automute_o, .compressed_frame_automute_en_o, .chan_status_automute_en_o,
        .coefficient_value_o, .coefficient_index_o, .coefficient_rw_o);
    initial forever #2.5 clk_i = ~clk_i;
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(negedge clk_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        `CHK({reg_rvalid_o, reg_rdata_o}, {1'b1, e})
    endtask
    task automatic t_status;
        rd(7'h76, 16'h0403);
        want = 4'h1;
        repeat (4) @(negedge clk_i);
        rd(7'h76, 16'h0400);
        wr(7'h76, 16'hFFFF);
        rd(7'h76, 16'h0C00);
        `CHK({compressed_frame_automute_en_o, chan_status_automute_en_o}, 2'b11)
        $display("Test status done");
    endtask
    task automatic t_mute;
        `CHK(automute_o, 1'b0)
        want = 4'h3;
        repeat (5) @(negedge clk_i);
        `CHK(automute_o, 1'b1)
        want = 4'h0;
        repeat (5) @(negedge clk_i);
        `CHK(automute_o, 1'b1)
        want = 4'h2;
        wr(7'h76, 16'h0000);
        repeat (4) @(negedge clk_i);
        `CHK(automute_o, 1'b0)
        $display("Test automute done");
    endtask
    task automatic t_coef;
        wr(7'h78, 16'hA5C3);
        wr(7'h7A, 16'h3CFF);
        `CHK({coefficient_value_o, coefficient_index_o, coefficient_rw_o}, 29'h1F4B8679)
        rd(7'h78, 16'hA5C3);
        rd(7'h7A, 16'h3C8F);
        $display("Test coefficient done");
    endtask
    task automatic t_id;
        wr(7'h7C, 16'hFFFF);
        wr(7'h7E, 16'h0000);
        rd(7'h7C, audio_regs_pkg::ID_FIRST_VAL);
        rd(7'h7E, {audio_regs_pkg::ID_SECOND_HI, audio_regs_pkg::REVISION_VAL});
        rd(7'h70, 16'h0000);
        $display("Test identity done");
    endtask
    task automatic results;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        t_status();
        t_mute();
        t_coef();
        t_id();
        results();
    end
    // Whole run is about fifty cycles
    initial begin
        #20000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
